/* File: rtl/osc_filter.sv */
// persistence filter: output rises once the input has held for a set number of cycles
`timescale 1ns/10ps
module osc_filter #(
  parameter int CW = 8
) (
  input  wire logic          i_clk,
  input  wire logic          i_rstn,
  input  wire logic          i_ce,
  input  wire logic          i_cond,
  input  wire logic [CW-1:0] i_len,
  output logic               o_held
);

  logic [CW-1:0] cnt_q;

  // any gap restarts the count, so glitches shorter than the window never act
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q  <= '0;
      o_held <= 1'b0;
    end else if (i_ce) begin
      if (!i_cond) begin
        cnt_q  <= '0;
        o_held <= 1'b0;
      end else if (cnt_q + 1'b1 >= i_len) begin
        o_held <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule // osc_filter

/* File: rtl/osc_map.svh */
// register map, field positions, thresholds and timing for the oring switch control
// ****************************************************************
// Summary of operation
// - The precise flag rises when the sense-resistor drop reaches the level chosen by bits [7:6]; code 00 is 0 mV, others reserved.
// - The switch is enabled when local sense a minus b exceeds -0.5, 0, 1 or 2 percent of full range per bits [5:4].
// - The quick path turns the switch off when the sense drop falls to -100, -75, -50 or -25 mV per bits [3:2].
// - The quick-off condition must persist for 40 ns (bit 1 low) or 200 ns (bit 1 high) before it acts.
// - With bit 0 set the quick path is ignored and only the precise path turns the switch off.
// - All of these settings live in one 8-bit read/write register at address 0x30.
// ****************************************************************
`ifndef OSC_MAP_SVH
`define OSC_MAP_SVH

`define OSC_ADDR_CFG       12'h030
`define OSC_ADDR_STATE     12'h034
`define OSC_ADDR_IRQ_STS   12'h038
`define OSC_ADDR_IRQ_CLR   12'h03c
`define OSC_ADDR_IRQ_EN    12'h040
`define OSC_CFG_RST        8'h00

`define OSC_PRECISE_MV_00  16'sh0000
`define OSC_QUICK_MV_00    -16'sd100
`define OSC_QUICK_MV_01    -16'sd75
`define OSC_QUICK_MV_10    -16'sd50
`define OSC_QUICK_MV_11    -16'sd25
// enable levels in half-percent steps of full range
`define OSC_ON_HP_00       -24'sd1
`define OSC_ON_HP_01       24'sd0
`define OSC_ON_HP_10       24'sd2
`define OSC_ON_HP_11       24'sd4
`define OSC_HP_PER_FULL    24'sd200

`define OSC_CLK_MHZ        250
`define OSC_FILT_SHORT_NS  40
`define OSC_FILT_LONG_NS   200

`define OSC_RESP_OKAY      2'h0
`define OSC_RESP_SLVERR    2'h2

`endif

/* File: rtl/osc_pkg.sv */
// types shared by the oring switch control files
package osc_pkg;

  typedef struct packed {
    logic [1:0] precise_flag_level;
    logic [1:0] switch_on_level;
    logic [1:0] quick_off_level;
    logic       quick_off_filter;
    logic       quick_off_skip;
  } osc_cfg_t;

  typedef struct packed {
    logic precise_off;
    logic quick_off;
    logic switch_on;
  } osc_evt_t;

  typedef enum logic [1:0] {
    OSC_OFF = 2'b01,
    OSC_ON  = 2'b10
  } osc_state_t;

endpackage

/* File: rtl/osc_top.sv */
// oring switch control with axi4-lite register access
`timescale 1ns/10ps
`include "osc_map.svh"
module osc_top import osc_pkg::*; #(
  parameter int AW = 12,
  parameter int FW = 8
) (
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  input  wire logic               i_ce,
  // samples from the on-chip sense adc, same clock
  input  wire logic signed [15:0] i_isense_pos,
  input  wire logic signed [15:0] i_isense_neg,
  input  wire logic        [11:0] i_local_vsense_a,
  input  wire logic        [11:0] i_local_vsense_b,
  output logic                    o_oring_switch_gate,
  output logic                    o_precise_flag,
  output logic                    o_irq,
  // axi4-lite slave
  input  wire logic [AW-1:0]      i_awaddr,
  input  wire logic               i_awvalid,
  output logic                    o_awready,
  input  wire logic [31:0]        i_wdata,
  input  wire logic [3:0]         i_wstrb,
  input  wire logic               i_wvalid,
  output logic                    o_wready,
  output logic [1:0]              o_bresp,
  output logic                    o_bvalid,
  input  wire logic               i_bready,
  input  wire logic [AW-1:0]      i_araddr,
  input  wire logic               i_arvalid,
  output logic                    o_arready,
  output logic [31:0]             o_rdata,
  output logic [1:0]              o_rresp,
  output logic                    o_rvalid,
  input  wire logic               i_rready
);

  localparam logic [FW-1:0] FILT_SHORT = FW'((`OSC_FILT_SHORT_NS * `OSC_CLK_MHZ + 999) / 1000);
  localparam logic [FW-1:0] FILT_LONG  = FW'((`OSC_FILT_LONG_NS * `OSC_CLK_MHZ + 999) / 1000);

  osc_cfg_t         cfg_q;
  osc_state_t       state_q;
  osc_evt_t         evt;
  logic [2:0]       irq_sts_q;
  logic [2:0]       irq_en_q;
  logic [AW-1:0]    awaddr_q;
  logic [AW-1:0]    araddr_w;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic             wr_go;
  logic             clr_hit;
  logic signed [16:0] drop;
  logic signed [16:0] quick_mv;
  logic signed [16:0] precise_mv;
  logic signed [23:0] vdiff_scaled;
  logic signed [23:0] on_scaled;
  logic signed [23:0] on_hp;
  logic             on_cond;
  logic             quick_raw;
  logic             quick_held;
  logic             off_cond;

  // ****************************************************************
  // threshold decode
  // ****************************************************************
  assign drop = 17'(i_isense_pos) - 17'(i_isense_neg);

  always_comb begin
    // reserved codes behave as code 00 so a bad write cannot leave the flag dead
    precise_mv = 17'(`OSC_PRECISE_MV_00);
    case (cfg_q.quick_off_level)
      2'b00:   quick_mv = 17'(`OSC_QUICK_MV_00);
      2'b01:   quick_mv = 17'(`OSC_QUICK_MV_01);
      2'b10:   quick_mv = 17'(`OSC_QUICK_MV_10);
      2'b11:   quick_mv = 17'(`OSC_QUICK_MV_11);
      default: quick_mv = 17'(`OSC_QUICK_MV_00);
    endcase
    case (cfg_q.switch_on_level)
      2'b00:   on_hp = `OSC_ON_HP_00;
      2'b01:   on_hp = `OSC_ON_HP_01;
      2'b10:   on_hp = `OSC_ON_HP_10;
      2'b11:   on_hp = `OSC_ON_HP_11;
      default: on_hp = `OSC_ON_HP_01;
    endcase
  end

  // compare in half-percent units, scaled so no fraction of a code is lost
  assign vdiff_scaled = (24'(signed'({1'b0, i_local_vsense_a})) - 24'(signed'({1'b0, i_local_vsense_b})))
                        * `OSC_HP_PER_FULL;
  assign on_scaled    = 24'(on_hp * 24'sd4096);
  assign on_cond      = vdiff_scaled > on_scaled;
  assign quick_raw    = (drop <= quick_mv) && !cfg_q.quick_off_skip;

  osc_filter #(
    .CW (FW)
  ) u_filter (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_ce   (i_ce),
    .i_cond (quick_raw),
    .i_len  (cfg_q.quick_off_filter ? FILT_LONG : FILT_SHORT),
    .o_held (quick_held)
  );

  // ****************************************************************
  // precise flag and gate state
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_precise_flag <= 1'b0;
    end else if (i_ce) begin
      o_precise_flag <= drop <= precise_mv;
    end
  end

  // the precise path acts on the registered flag: one cycle later, but glitch free
  assign off_cond = o_precise_flag || quick_held;

  always_comb begin
    evt.switch_on   = (state_q == OSC_OFF) && on_cond && i_ce;
    evt.quick_off   = (state_q == OSC_ON) && quick_held && i_ce;
    evt.precise_off = (state_q == OSC_ON) && o_precise_flag && i_ce;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q             <= OSC_OFF;
      o_oring_switch_gate <= 1'b0;
    end else if (i_ce) begin
      case (state_q)
        OSC_OFF: begin
          if (on_cond) begin
            state_q             <= OSC_ON;
            o_oring_switch_gate <= 1'b1;
          end
        end
        OSC_ON: begin
          if (off_cond) begin
            state_q             <= OSC_OFF;
            o_oring_switch_gate <= 1'b0;
          end
        end
        default: begin
          state_q             <= OSC_OFF;
          o_oring_switch_gate <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // axi4-lite write path
  // ****************************************************************
  assign wr_go   = !o_awready && !o_wready && !o_bvalid;
  assign clr_hit = wr_go && awaddr_q == `OSC_ADDR_IRQ_CLR && wstrb_q[0];

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= `OSC_RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else if (i_ce) begin
      if (i_awvalid && o_awready) begin
        awaddr_q  <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (wr_go) begin
        o_bvalid <= 1'b1;
        case (awaddr_q)
          `OSC_ADDR_CFG, `OSC_ADDR_IRQ_CLR, `OSC_ADDR_IRQ_EN, `OSC_ADDR_STATE, `OSC_ADDR_IRQ_STS:
            o_bresp <= `OSC_RESP_OKAY;
          default:
            o_bresp <= `OSC_RESP_SLVERR;
        endcase
      end
      if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_q    <= osc_cfg_t'(`OSC_CFG_RST);
      irq_en_q <= '0;
    end else if (i_ce && wr_go && wstrb_q[0]) begin
      if (awaddr_q == `OSC_ADDR_CFG) begin
        cfg_q <= osc_cfg_t'(wdata_q[7:0]);
      end
      if (awaddr_q == `OSC_ADDR_IRQ_EN) begin
        irq_en_q <= wdata_q[2:0];
      end
    end
  end

  // ****************************************************************
  // interrupts: a new event in the clearing cycle stays set
  // ****************************************************************
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_sts_q <= '0;
      o_irq     <= 1'b0;
    end else if (i_ce) begin
      irq_sts_q <= (irq_sts_q & ~(clr_hit ? wdata_q[2:0] : 3'h0)) | evt;
      o_irq     <= |(((irq_sts_q & ~(clr_hit ? wdata_q[2:0] : 3'h0)) | evt) & irq_en_q);
    end
  end

  // ****************************************************************
  // axi4-lite read path
  // ****************************************************************
  assign araddr_w = i_araddr;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= `OSC_RESP_OKAY;
    end else if (i_ce) begin
      if (i_arvalid && o_arready) begin
        o_arready <= 1'b0;
        o_rvalid  <= 1'b1;
        o_rresp   <= `OSC_RESP_OKAY;
        case (araddr_w)
          `OSC_ADDR_CFG:     o_rdata <= {24'h0, cfg_q};
          `OSC_ADDR_STATE:   o_rdata <= {29'h0, quick_held, o_precise_flag, o_oring_switch_gate};
          `OSC_ADDR_IRQ_STS: o_rdata <= {29'h0, irq_sts_q};
          `OSC_ADDR_IRQ_EN:  o_rdata <= {29'h0, irq_en_q};
          `OSC_ADDR_IRQ_CLR: o_rdata <= 32'h0;
          default: begin
            o_rdata <= 32'h0;
            o_rresp <= `OSC_RESP_SLVERR;
          end
        endcase
      end
      if (o_rvalid && i_rready) begin
        o_rvalid  <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

endmodule // osc_top

/* File: tb/oring_switch_control_tb.sv */
// self-checking bench for the oring switch control
`timescale 1ns/10ps
`include "osc_map.svh"
module oring_switch_control_tb import osc_pkg::*;;
  logic               clk, rstn, ce, gate, flag, irq, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [11:0]        awa, ara, va, vb;
  logic [31:0]        wd, rd, x;
  logic [3:0]         ws;
  logic [1:0]         bresp, rresp, r;
  logic signed [15:0] load, ipos, ineg;
  int                 n_errors, tests_run, cyc, d, n;
  int                 edge_d[4] = '{-20, 1, 41, 82};
  int                 lvl[4] = '{-100, -75, -50, -25};
  osc_cfg_t           cfg;
  osc_top u_osc_top (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_isense_pos(ipos), .i_isense_neg(ineg),
    .i_local_vsense_a(va), .i_local_vsense_b(vb), .o_oring_switch_gate(gate), .o_precise_flag(flag),
    .o_irq(irq), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(ws),
    .i_wvalid(wv), .o_wready(wr), .o_bresp(bresp), .o_bvalid(bv), .i_bready(br), .i_araddr(ara),
    .i_arvalid(arv), .o_arready(arr), .o_rdata(rd), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rr));
  osc_fet_model u_osc_fet_model (.i_gate(gate), .i_load_mv(load), .o_isense_pos(ipos), .o_isense_neg(ineg));
  // ********************************
  // tasks
  // ********************************
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] dt, input logic [3:0] s);
    @(posedge clk);
    awa <= a;
    wd <= dt;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (awv && !awr || wv && !wr);
    // late ready exercises the held response
    repeat ($urandom_range(2)) @(posedge clk);
    br <= 1'b1;
    do @(posedge clk); while (!bv);
    br <= 1'b0;
    r = bresp;
  endtask
  task automatic bus_rd(input logic [11:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    repeat ($urandom_range(2)) @(posedge clk);
    rr <= 1'b1;
    do @(posedge clk); while (!rv);
    rr <= 1'b0;
    x = rd;
    r = rresp;
  endtask
  task automatic park();
    va <= 12'h000;
    vb <= 12'hfa0;
    load <= -16'sd10;
    repeat (4) @(posedge clk);
    load <= 16'sd50;
    repeat (2) @(posedge clk);
  endtask
  function automatic logic exp_on(input int c, input int dd);
    int hp[4] = '{-1, 0, 2, 4};
    return dd * 200 > hp[c] * 4096;
  endfunction
  task automatic finish_test();
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {clk, rstn, awv, wv, br, arv, rr} = '0;
    ce = 1'b1;
    {awa, ara, wd, ws, va, vb, load} = '0;
    {n_errors, tests_run, cyc} = '0;
    void'($urandom(12));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    bus_rd(`OSC_ADDR_CFG);
    chk("cfg reset", 32'h0, x);
    bus_rd(12'h100);
    chk("unmapped resp", 32'h2, 32'(r));
    bus_wr(12'h100, 32'h0, 4'hf);
    chk("unmapped bresp", 32'h2, 32'(r));
    repeat (4) begin
      cfg = 8'($urandom);
      bus_wr(`OSC_ADDR_CFG, {24'h0, cfg}, 4'hf);
      chk("cfg bresp", 32'h0, 32'(r));
      bus_rd(`OSC_ADDR_CFG);
      chk("cfg", {24'h0, cfg}, x);
    end
    bus_wr(`OSC_ADDR_CFG, 32'hff, 4'h0);
    bus_rd(`OSC_ADDR_CFG);
    chk("cfg no strobe", {24'h0, cfg}, x);
    for (int c = 0; c < 4; c++) begin
      cfg = '{2'b00, 2'(c), 2'b00, 1'b0, 1'b1};
      bus_wr(`OSC_ADDR_CFG, {24'h0, cfg}, 4'h1);
      for (int k = 0; k < 3; k++) begin
        d = (k == 2) ? int'($urandom_range(130)) - 30 : edge_d[c] - 1 + k;
        park();
        vb <= 12'h800;
        va <= 12'(2048 + d);
        repeat (3) @(posedge clk);
        chk("gate on", 32'(exp_on(c, d)), 32'(gate));
      end
    end
    va <= 12'hfff;
    repeat (3) @(posedge clk);
    load <= 16'sh0000;
    repeat (2) @(posedge clk);
    chk("flag", 32'h1, 32'(flag));
    chk("gate held", 32'h1, 32'(gate));
    @(posedge clk);
    chk("gate off", 32'h0, 32'(gate));
    park();
    bus_wr(`OSC_ADDR_IRQ_CLR, 32'h7, 4'hf);
    bus_wr(`OSC_ADDR_IRQ_EN, 32'h1, 4'hf);
    chk("irq idle", 32'h0, 32'(irq));
    vb <= 12'h800;
    va <= 12'hfff;
    repeat (3) @(posedge clk);
    chk("irq set", 32'h1, 32'(irq));
    bus_wr(`OSC_ADDR_IRQ_EN, 32'h0, 4'hf);
    @(posedge clk);
    chk("irq masked", 32'h0, 32'(irq));
    bus_wr(`OSC_ADDR_IRQ_CLR, 32'h1, 4'hf);
    bus_wr(`OSC_ADDR_IRQ_EN, 32'h1, 4'hf);
    @(posedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    // enable low must freeze the gate and the flag although the drop goes negative
    ce <= 1'b0;
    load <= -16'sd10;
    repeat (3) @(posedge clk);
    chk("ce freeze gate", 32'h1, 32'(gate));
    chk("ce freeze flag", 32'h0, 32'(flag));
    ce <= 1'b1;
    // quick path seen through sticky status: the enable level keeps re-closing the switch
    // between precise trips, so the filtered quick-off meets it closed
    for (int f = 0; f < 2; f++)
      for (int q = 0; q < 4; q++)
        for (int k = 0; k < 4; k++) begin
          n = f ? 50 : 10;
          cfg = '{2'b00, 2'b00, 2'(q), 1'(f), k == 3};
          bus_wr(`OSC_ADDR_CFG, {24'h0, cfg}, 4'hf);
          park();
          vb <= 12'h800;
          va <= 12'hfff;
          bus_wr(`OSC_ADDR_IRQ_CLR, 32'h7, 4'hf);
          load <= 16'(lvl[q] + (k == 2));
          repeat (n - 1 + 2 * (k > 0)) @(posedge clk);
          load <= 16'sd50;
          bus_rd(`OSC_ADDR_IRQ_STS);
          chk("quick off", 32'(k == 1), 32'(x[1]));
        end
    finish_test();
  end
endmodule // oring_switch_control_tb

/* File: tb/osc_fet_model.sv */
// behavioural oring transistor with its sense resistor
`timescale 1ns/10ps
module osc_fet_model (
  input  wire logic               i_gate,
  input  wire logic signed [15:0] i_load_mv,
  output logic signed [15:0]      o_isense_pos,
  output logic signed [15:0]      o_isense_neg
);
  // switch off: forward current takes the body diode, so the drop grows
  assign o_isense_neg = 16'sh03e8;
  assign o_isense_pos = o_isense_neg + ((!i_gate && i_load_mv > 0) ? i_load_mv + 16'sh0014 : i_load_mv);
endmodule // osc_fet_model

/* File: tb/osc_props.sv */
// port assertions for the oring switch control
`timescale 1ns/10ps
module osc_props (
  input wire logic               i_clk,
  input wire logic               i_rstn,
  input wire logic               i_ce,
  input wire logic signed [15:0] i_isense_pos,
  input wire logic signed [15:0] i_isense_neg,
  input wire logic               o_oring_switch_gate,
  input wire logic               o_precise_flag,
  input wire logic               i_awvalid,
  input wire logic               i_wvalid,
  input wire logic               o_awready,
  input wire logic               o_wready,
  input wire logic               o_bvalid,
  input wire logic               i_bready,
  input wire logic               i_arvalid,
  input wire logic               o_arready,
  input wire logic               o_rvalid,
  input wire logic               i_rready,
  input wire logic [31:0]        o_rdata
);
  logic               up_q;
  logic signed [16:0] drop;
  assign drop = 17'(i_isense_pos) - 17'(i_isense_neg);
  // the first edge after release still shows reset values
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn) up_q <= 1'b0;
    else up_q <= 1'b1;
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_rstn || !up_q || !i_ce);
  a_flag_set: assert property (i_ce && drop <= 17'sh00000 |=> o_precise_flag)
    else $error("precise flag missing");
  a_flag_clear: assert property (i_ce && drop > 17'sh00000 |=> !o_precise_flag)
    else $error("precise flag stuck");
  a_precise_off: assert property (i_ce && o_precise_flag && o_oring_switch_gate |=> !o_oring_switch_gate)
    else $error("gate not dropped by precise path");
  a_write_lat: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> ##1 o_bvalid)
    else $error("write response late");
  a_read_lat: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");
  a_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response withdrawn");
  a_rvalid_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data withdrawn");
  a_wr_blocked: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while response pending");
  a_rd_blocked: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while data pending");
endmodule // osc_props
bind osc_top osc_props u_osc_props (.i_clk, .i_rstn, .i_ce, .i_isense_pos, .i_isense_neg, .o_oring_switch_gate,
  .o_precise_flag, .i_awvalid, .i_wvalid, .o_awready, .o_wready, .o_bvalid, .i_bready, .i_arvalid, .o_arready,
  .o_rvalid, .i_rready, .o_rdata);
